//--- common/amc_regs.svh
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH

// ****************************************
// Register indices (byte address divided by four)
// ****************************************
`define AMC_IDX_CTRL0 8'h00
`define AMC_IDX_CTRL1 8'h01
`define AMC_IDX_CTRL2 8'h02
`define AMC_IDX_CLKGATE 8'h03
`define AMC_IDX_STOP 8'h04

// ****************************************
// Field positions and write masks
// ****************************************
`define AMC_EN_BIT 7
`define AMC_LP_BIT 6
`define AMC_MASK_CTRL0 8'hc3
`define AMC_MASK_CTRL1 8'h1f
`define AMC_MASK_CTRL2 8'h77
`define AMC_MASK_CLKGATE 8'h01
`define AMC_MASK_STOP 8'h03

// ****************************************
// Reset values
// ****************************************
`define AMC_RST_CTRL0 8'h00
`define AMC_RST_CTRL1 8'h00
`define AMC_RST_CTRL2 8'h00
`define AMC_RST_CLKGATE 8'h01
`define AMC_RST_STOP 8'h00

// ****************************************
// Bus answers
// ****************************************
`define AMC_RESP_OKAY 2'b00
`define AMC_RESP_SLVERR 2'b10

`endif

//--- common/amc_pkg.sv
package amc_pkg;

  // Amplifier configuration codes
  typedef enum logic [1:0] {
    AMC_CFG_BUFFER = 2'h0,
    AMC_CFG_INVERTING = 2'h1,
    AMC_CFG_GENERAL = 2'h2,
    AMC_CFG_NONINVERTING = 2'h3
  } amc_cfg_t;

  // Power state of the processor, as seen by the amplifier
  typedef enum logic [1:0] {
    AMC_PWR_RUN = 2'h0,
    AMC_PWR_WAIT = 2'h1,
    AMC_PWR_STOP3 = 2'h2,
    AMC_PWR_DEEP_STOP = 2'h3
  } amc_pwr_t;

  // Input route codes
  typedef enum logic [2:0] {
    AMC_ROUTE_PIN = 3'h0,
    AMC_ROUTE_FIRST_AMP = 3'h1,
    AMC_ROUTE_SECOND_AMP = 3'h2,
    AMC_ROUTE_RESERVED = 3'h3,
    AMC_ROUTE_DAC5 = 3'h4,
    AMC_ROUTE_DAC12 = 3'h5,
    AMC_ROUTE_SUPPLY = 3'h6,
    AMC_ROUTE_GROUND = 3'h7
  } amc_route_t;

  typedef enum logic [1:0] {
    AMC_WR_IDLE,
    AMC_WR_RESP
  } amc_wr_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] clkgate;
    logic [7:0] stop;
    logic aw_held;
    logic [7:0] aw_idx;
    logic aw_bad;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    amc_wr_t wr;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } amc_state_t;

endpackage

//--- design/amc_regs_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "amc_regs.svh"
// Functional notes
// - Three control registers at offsets 0,1,2
// - Bit 7 clear keeps amplifier unpowered
// - Enable ignored in deep stop only
// - Bit 6 selects low power over speed
// - Bits 1:0 choose the amplifier configuration
// - Register 2 bits 6:4 route positive input
// - Register 2 bits 2:0 route negative input
// - Gain follows mode and resistor selects
// - Enable low keeps stop3/wait unpowered
// - Own clock gate bit, set after reset
module amc_regs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic amp_power_enable,
  output logic low_power_select,
  output amc_pkg::amc_cfg_t amp_config,
  output logic [1:0] input_resistor_select,
  output logic [2:0] feedback_resistor_select,
  output logic [5:0] gain_halves,
  output logic gain_valid,
  output amc_pkg::amc_route_t positive_input_route,
  output amc_pkg::amc_route_t negative_input_route,
  output logic bus_clock_enable
);
  import amc_pkg::*;

  amc_state_t state;
  amc_state_t next_state;

  // ****************************************
  // Address decode and gain lookup
  // ****************************************

  // Byte address to register index; only addresses below 0x14 map, bits 1:0 ignored
  function automatic logic [8:0] decode(input logic [31:0] addr);
    logic [7:0] idx;
    logic bad;
    idx = addr[9:2];
    bad = (addr[31:10] != 22'h000000) || (idx > `AMC_IDX_STOP);
    decode = {bad, idx};
  endfunction

  // Write mask per register keeps reserved bits at zero
  function automatic logic [7:0] wmask(input logic [7:0] idx);
    case (idx)
      `AMC_IDX_CTRL0: wmask = `AMC_MASK_CTRL0;
      `AMC_IDX_CTRL1: wmask = `AMC_MASK_CTRL1;
      `AMC_IDX_CTRL2: wmask = `AMC_MASK_CTRL2;
      `AMC_IDX_CLKGATE: wmask = `AMC_MASK_CLKGATE;
      `AMC_IDX_STOP: wmask = `AMC_MASK_STOP;
      default: wmask = 8'h00;
    endcase
  endfunction

  // Gain in halves (7/2 -> 7); zero means no defined gain
  // Six bits, since the largest gain (17) doubles to 34
  function automatic logic [5:0] gain_lookup(input logic [1:0] cfg, input logic [1:0] ri,
                                             input logic [2:0] rf);
    logic [5:0] g;
    g = 6'h00;
    if (cfg == AMC_CFG_INVERTING && ri == 2'h0) begin
      case (rf)
        3'h1: g = 6'h06;
        3'h2: g = 6'h0a;
        3'h3: g = 6'h10;
        3'h4: g = 6'h18;
        3'h5: g = 6'h20;
        default: g = 6'h00;
      endcase
    end else if (cfg == AMC_CFG_INVERTING && ri == 2'h1) begin
      case (rf)
        3'h1: g = 6'h02;
        3'h2: g = 6'h04;
        3'h3: g = 6'h07;
        3'h4: g = 6'h0b;
        3'h5: g = 6'h0f;
        default: g = 6'h00;
      endcase
    end else if (cfg == AMC_CFG_NONINVERTING && ri == 2'h0) begin
      case (rf)
        3'h1: g = 6'h08;
        3'h2: g = 6'h0c;
        3'h3: g = 6'h12;
        3'h4: g = 6'h1a;
        3'h5: g = 6'h22;
        default: g = 6'h00;
      endcase
    end else if (cfg == AMC_CFG_NONINVERTING && ri == 2'h1) begin
      case (rf)
        3'h1: g = 6'h04;
        3'h2: g = 6'h06;
        3'h3: g = 6'h09;
        3'h4: g = 6'h0d;
        3'h5: g = 6'h11;
        default: g = 6'h00;
      endcase
    end
    gain_lookup = g;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************

  // Bus slave: address and data latched in either order, one answer each
  always_comb begin
    logic [8:0] dec;
    logic [7:0] m;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    dec = 9'h000;
    m = 8'h00;
    wbyte = 8'h00;
    rbyte = 8'h00;
    next_state = state;
    if (s_axi_awvalid && s_axi_awready) begin
      dec = decode(s_axi_awaddr);
      next_state.aw_held = 1'b1;
      next_state.aw_idx = dec[7:0];
      next_state.aw_bad = dec[8];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    case (state.wr)
      AMC_WR_IDLE: begin
        if (state.aw_held && state.w_held) begin
          next_state.aw_held = 1'b0;
          next_state.w_held = 1'b0;
          next_state.wr = AMC_WR_RESP;
          next_state.bresp = state.aw_bad ? `AMC_RESP_SLVERR : `AMC_RESP_OKAY;
          // Only the low byte lane carries register data
          if (!state.aw_bad && state.w_strb[0]) begin
            m = wmask(state.aw_idx);
            wbyte = state.w_data[7:0] & m;
            case (state.aw_idx)
              `AMC_IDX_CTRL0: next_state.ctrl0 = wbyte;
              `AMC_IDX_CTRL1: next_state.ctrl1 = wbyte;
              `AMC_IDX_CTRL2: next_state.ctrl2 = wbyte;
              `AMC_IDX_CLKGATE: next_state.clkgate = wbyte;
              `AMC_IDX_STOP: next_state.stop = wbyte;
              default: next_state.stop = state.stop;
            endcase
          end
        end
      end
      AMC_WR_RESP: begin
        if (s_axi_bready) begin
          next_state.wr = AMC_WR_IDLE;
        end
      end
      default: next_state.wr = AMC_WR_IDLE;
    endcase
    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      dec = decode(s_axi_araddr);
      case (dec[7:0])
        `AMC_IDX_CTRL0: rbyte = state.ctrl0;
        `AMC_IDX_CTRL1: rbyte = state.ctrl1;
        `AMC_IDX_CTRL2: rbyte = state.ctrl2;
        `AMC_IDX_CLKGATE: rbyte = state.clkgate;
        `AMC_IDX_STOP: rbyte = state.stop;
        default: rbyte = 8'h00;
      endcase
      next_state.rvalid = 1'b1;
      next_state.rdata = dec[8] ? 32'h00000000 : {24'h000000, rbyte};
      next_state.rresp = dec[8] ? `AMC_RESP_SLVERR : `AMC_RESP_OKAY;
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Synchronous reset; clock gate bit comes up set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.ctrl0 <= `AMC_RST_CTRL0;
      state.ctrl1 <= `AMC_RST_CTRL1;
      state.ctrl2 <= `AMC_RST_CTRL2;
      state.clkgate <= `AMC_RST_CLKGATE;
      state.stop <= `AMC_RST_STOP;
      state.wr <= AMC_WR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Holding a taken item blocks the next one until the write completes
  assign s_axi_awready = !state.aw_held && state.wr == AMC_WR_IDLE;
  assign s_axi_wready = !state.w_held && state.wr == AMC_WR_IDLE;
  assign s_axi_bvalid = state.wr == AMC_WR_RESP;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;

  // Deep stop forces power off regardless; stop3 and wait follow the bit
  assign amp_power_enable = state.ctrl0[`AMC_EN_BIT] &&
                            (state.stop[1:0] != AMC_PWR_DEEP_STOP);
  assign low_power_select = state.ctrl0[`AMC_LP_BIT];
  assign amp_config = amc_cfg_t'(state.ctrl0[1:0]);
  assign input_resistor_select = state.ctrl1[1:0];
  assign feedback_resistor_select = state.ctrl1[4:2];
  assign gain_halves = gain_lookup(state.ctrl0[1:0], state.ctrl1[1:0], state.ctrl1[4:2]);
  assign gain_valid = gain_halves != 6'h00;
  assign positive_input_route = amc_route_t'(state.ctrl2[6:4]);
  assign negative_input_route = amc_route_t'(state.ctrl2[2:0]);
  assign bus_clock_enable = state.clkgate[0];

endmodule

//--- bench/amc_regs_checker.sv
`timescale 1ns/1ps
// ****************************************
// Bus handshake and gain checks
// ****************************************
module amc_regs_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire amc_pkg::amc_cfg_t amp_config,
  input wire logic [1:0] input_resistor_select,
  input wire logic [2:0] feedback_resistor_select,
  input wire logic [5:0] gain_halves,
  input wire logic gain_valid
);
  import amc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write answers within two cycles, no new write while one is pending
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while pending");
  // Read answers next cycle; unused upper bits stay zero
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer kept");
  // Gain only in the gain configurations, with the known example value
  a_gain_example: assert property (amp_config == AMC_CFG_INVERTING &&
    input_resistor_select == 2'h0 && feedback_resistor_select == 3'h1 |-> gain_halves == 6'h06)
    else $error("gain example wrong");
  a_gain_mode: assert property (!amp_config[0] |-> !gain_valid)
    else $error("gain outside gain modes");
  a_gain_undef: assert property (feedback_resistor_select inside {3'h0, 3'h6, 3'h7}
    |-> !gain_valid) else $error("undefined gain flagged");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_awready == 1'b0);
  cover property (gain_valid);
endmodule

bind amc_regs_top amc_regs_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .amp_config, .input_resistor_select,
  .feedback_resistor_select, .gain_halves, .gain_valid);

//--- bench/amc_regs_top_tb.sv
`timescale 1ns/1ps
`include "amc_regs.svh"
module amc_regs_top_tb;
  import amc_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, input_resistor_select;
  logic s_axi_rvalid, amp_power_enable, low_power_select, gain_valid, bus_clock_enable;
  logic [2:0] feedback_resistor_select;
  logic [5:0] gain_halves;
  amc_cfg_t amp_config;
  amc_route_t positive_input_route, negative_input_route;
  int num_errors = 0, check_count = 0;
  // Gain cases: mode, input select, feedback select, gain times two
  // Fields: mode 12:11, input select 10:9, feedback select 8:6, gain 5:0
  logic [12:0] gain_tbl [0:9] = '{13'h0846, 13'h0ac7, 13'h191a, 13'h1b51,
    13'h0980, 13'h0040, 13'h1280, 13'h0a42, 13'h1962, 13'h0960};
  // ****************************************
  // Clock and device
  // ****************************************
  always #25 aclk = ~aclk;
  amc_regs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .amp_power_enable, .low_power_select,
    .amp_config, .input_resistor_select, .feedback_resistor_select, .gain_halves,
    .gain_valid, .positive_input_route, .negative_input_route, .bus_clock_enable);
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp === r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata === d && s_axi_rresp === r);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(32'h0, 32'h0, `AMC_RESP_OKAY);
    rd(32'h4, 32'h0, `AMC_RESP_OKAY);
    rd(32'h8, 32'h0, `AMC_RESP_OKAY);
    rd(32'hc, 32'h1, `AMC_RESP_OKAY);
    chk(bus_clock_enable === 1'b1);
  endtask
  // All ones written; reserved places must come back zero
  task automatic t_mask;
    wr(32'h0, 8'hff, `AMC_RESP_OKAY);
    rd(32'h0, 32'hc3, `AMC_RESP_OKAY);
    wr(32'h4, 8'hff, `AMC_RESP_OKAY);
    rd(32'h4, 32'h1f, `AMC_RESP_OKAY);
    wr(32'h8, 8'hff, `AMC_RESP_OKAY);
    rd(32'h8, 32'h77, `AMC_RESP_OKAY);
  endtask
  task automatic t_power;
    for (int p = 0; p < 4; p++) begin
      wr(32'h10, 8'(p), `AMC_RESP_OKAY);
      wr(32'h0, 8'h80, `AMC_RESP_OKAY);
      chk(amp_power_enable === (p != 3));
      wr(32'h0, 8'h00, `AMC_RESP_OKAY);
      chk(amp_power_enable === 1'b0);
    end
    wr(32'h10, 8'h00, `AMC_RESP_OKAY);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      wr(32'h0, {1'b0, i[0], 4'h0, i[1:0]}, `AMC_RESP_OKAY);
      chk(amp_config === amc_cfg_t'(i[1:0]));
      chk(low_power_select === i[0]);
    end
  endtask
  // Opposite codes on the two inputs so a swap shows
  task automatic t_routes;
    for (int i = 0; i < 8; i++) begin
      wr(32'h8, {1'b0, 3'(i), 1'b0, 3'(7 - i)}, `AMC_RESP_OKAY);
      chk(positive_input_route === 3'(i));
      chk(negative_input_route === 3'(7 - i));
    end
  endtask
  task automatic t_gain;
    logic [12:0] e;
    for (int i = 0; i < 10; i++) begin
      e = gain_tbl[i];
      wr(32'h4, {3'h0, e[8:6], e[10:9]}, `AMC_RESP_OKAY);
      wr(32'h0, {6'h0, e[12:11]}, `AMC_RESP_OKAY);
      chk(input_resistor_select === e[10:9] && feedback_resistor_select === e[8:6]);
      chk(gain_halves === e[5:0] && gain_valid === (e[5:0] != 6'h0));
    end
  endtask
  // A write with the low byte lane off must leave the register alone
  task automatic t_strb;
    s_axi_wstrb <= 4'he;
    wr(32'h8, 8'h11, `AMC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(32'h8, 32'h70, `AMC_RESP_OKAY);
  endtask
  // Reset in mid-run brings control register 0 and the clock gate back to their start values
  task automatic t_rerst;
    wr(32'h0, 8'h80, `AMC_RESP_OKAY);
    chk(amp_power_enable === 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(amp_power_enable === 1'b0 && bus_clock_enable === 1'b1);
    rd(32'h0, 32'h0, `AMC_RESP_OKAY);
    rd(32'hc, 32'h1, `AMC_RESP_OKAY);
  endtask
  task automatic t_bus;
    wr(32'h20, 8'h55, `AMC_RESP_SLVERR);
    rd(32'h20, 32'h0, `AMC_RESP_SLVERR);
    wr(32'hc, 8'h00, `AMC_RESP_OKAY);
    chk(bus_clock_enable === 1'b0);
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_mask;
    t_power;
    t_modes;
    t_routes;
    t_strb;
    t_gain;
    t_bus;
    t_rerst;
    report_and_stop;
  end
  // About sixteen times the expected run, so a hung handshake ends the test
  initial begin
    #200000;
    num_errors++;
    report_and_stop;
  end
endmodule
